// ===== core/agz_pkg.sv
// package: register map, field layout and timing for gain/zone/reset block
package agz_pkg;
	localparam int          NCH           = 2;
	localparam int          SMP_W         = 14;
	localparam int          COEF_W        = 16;
	localparam int          COEF_FRAC     = 12;
	localparam int          ADR_W         = 10;
	// page codes held in the page select register
	localparam logic [23:0] PG_GAIN_A     = 24'h610005;
	localparam logic [23:0] PG_GAIN_B     = 24'h610105;
	localparam logic [23:0] PG_MAIN_A     = 24'h680000;
	localparam logic [23:0] PG_MAIN_B     = 24'h680001;
	// word indices; byte address is four times the index
	localparam logic [9:0]  IDX_CORE_RST  = 10'h000;
	localparam logic [9:0]  IDX_ZONE      = 10'h0A2;
	localparam logic [9:0]  IDX_GAIN      = 10'h0A6;
	localparam logic [9:0]  IDX_PAGE      = 10'h100;
	localparam logic [9:0]  IDX_STAT      = 10'h101;
	// field positions
	localparam int          RST_BIT       = 0;
	localparam int          ZEN_BIT       = 3;
	localparam int          ZSEL_LSB      = 0;
	localparam int          ZSEL_W        = 3;
	localparam int          GAIN_LSB      = 0;
	localparam int          GAIN_W        = 4;
	localparam int          PAGE_W        = 24;
	localparam int          ST_RST_BIT    = 0;
	localparam int          ST_PEND_LSB   = 1;
	localparam int          ST_ZONE_A_LSB = 4;
	localparam int          ST_ZONE_B_LSB = 8;
	// reset values
	localparam logic        CORE_RST_RST  = 1'b0;
	localparam logic        ZEN_RST       = 1'b0;
	localparam logic [2:0]  ZSEL_RST      = 3'h0;
	localparam logic [3:0]  GAIN_RST      = 4'h0;
	localparam logic [23:0] PAGE_RST      = 24'h000000;
	// gain codes above this one are forbidden
	localparam logic [3:0]  GAIN_MAX      = 4'hB;
	// band codes
	localparam logic [2:0]  ZONE_FIRST    = 3'h0;
	localparam logic [2:0]  ZONE_SECOND   = 3'h1;
	localparam logic [2:0]  ZONE_THIRD    = 3'h2;
	// 10^(k/20) in Q4.12 for k = 0..11 dB
	localparam logic [15:0] GAIN_LUT [12] = '{
		16'h1000, 16'h11F4, 16'h1425, 16'h169A, 16'h195C, 16'h1C74,
		16'h1FED, 16'h23D2, 16'h2831, 16'h2D18, 16'h3299, 16'h38C5};
	// timing
	localparam int          MCLK_NS       = 25;
	localparam int          CORE_RST_NS   = 100;
	localparam int          CORE_RST_CYC  = (CORE_RST_NS + MCLK_NS - 1)
	                                        / MCLK_NS;
	typedef enum logic [1:0] {
		AGZ_SEQ_IDLE = 2'b00,
		AGZ_SEQ_FIRE = 2'b01,
		AGZ_SEQ_HOLD = 2'b10
	} agz_seq_t;
endpackage : agz_pkg

// ===== core/agz_gain_scale.sv
// per-channel digital gain stage ahead of the down-converter
`timescale 1ns/10ps
module agz_gain_scale
	import agz_pkg::*;
#(
	parameter int SW = agz_pkg::SMP_W
) (
	input  wire logic                  mclk,
	input  wire logic                  rst,
	input  wire logic                  core_rst,
	input  wire logic [agz_pkg::GAIN_W-1:0] gain_code,
	input  wire logic [SW-1:0]         smp_in,
	input  wire logic                  smp_in_vld,
	output logic      [SW-1:0]         smp_out,
	output logic                       smp_out_vld
);
	localparam int PW = SW + COEF_W + 1;
	localparam logic signed [PW-1:0] SMAX = PW'((1 <<< (SW - 1)) - 1);
	localparam logic signed [PW-1:0] SMIN = -PW'(1 <<< (SW - 1));

	logic        [COEF_W-1:0] coef;
	logic signed [PW-1:0]     prod;
	logic signed [PW-1:0]     shifted;
	logic        [SW-1:0]     sat_nxt;

	// forbidden codes fall back to unity rather than an undefined gain
	always_comb begin
		if (gain_code <= GAIN_MAX) begin
			coef = GAIN_LUT[gain_code];
		end else begin
			coef = GAIN_LUT[0];
		end
		prod    = PW'($signed(smp_in)) * $signed({1'b0, coef});
		shifted = prod >>> COEF_FRAC;
		if (shifted > SMAX) begin
			sat_nxt = SMAX[SW-1:0];
		end else if (shifted < SMIN) begin
			sat_nxt = SMIN[SW-1:0];
		end else begin
			sat_nxt = shifted[SW-1:0];
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			smp_out     <= '0;
			smp_out_vld <= 1'b0;
		end else if (core_rst) begin
			smp_out     <= '0;
			smp_out_vld <= 1'b0;
		end else begin
			smp_out     <= sat_nxt;
			smp_out_vld <= smp_in_vld;
		end
	end
endmodule : agz_gain_scale

// ===== core/agz_cfg_regs.sv
// gain, core reset and band zone configuration registers on wishbone
//
// Behaviour
// - samples get 0 to 11 dB gain in 1 dB steps before down-conversion
// - each channel has its own gain register, chosen by register page
// - writing the reset bit 0-1-0 resets the whole core for both channels
// - new zone settings take effect only when the core reset is pulsed
// - zone enable bit 3 switches operating zone specification off or on
// - band select covers spectrum outside band table, or all when table off
// - band code 000 first, 001 second, 010 third band
// - each channel has its own main page with reset and zone registers
//
// Our own choice: the Wishbone register port.
`timescale 1ns/10ps
module agz_cfg_regs
	import agz_pkg::*;
(
	input  wire logic                   mclk,
	input  wire logic                   rst,
	// classic wishbone slave
	input  wire logic                   wb_cyc_i,
	input  wire logic                   wb_stb_i,
	input  wire logic                   wb_we_i,
	input  wire logic [11:0]            wb_adr_i,
	input  wire logic [3:0]             wb_sel_i,
	input  wire logic [31:0]            wb_dat_i,
	output logic      [31:0]            wb_dat_o,
	output logic                        wb_ack_o,
	// sample path, same clock
	input  wire logic [agz_pkg::SMP_W-1:0] smp_a_i,
	input  wire logic [agz_pkg::SMP_W-1:0] smp_b_i,
	input  wire logic                   smp_vld_i,
	output logic      [agz_pkg::SMP_W-1:0] dwn_smp_a,
	output logic      [agz_pkg::SMP_W-1:0] dwn_smp_b,
	output logic      [1:0]             dwn_smp_vld,
	// band table enables from the table logic, same clock
	input  wire logic                   band_tab_en_a,
	input  wire logic                   band_tab_en_b,
	// core reset and applied zone configuration
	output logic                        core_rst_o,
	output logic      [1:0]             zone_en_o,
	output logic      [2:0]             zone_sel_a_o,
	output logic      [2:0]             zone_sel_b_o,
	output logic      [2:0]             zone_band_a_o,
	output logic      [2:0]             zone_band_b_o,
	output logic      [1:0]             zone_whole_o
);
	import agz_pkg::*;

	localparam logic [2:0] CNT_LOAD = 3'(CORE_RST_CYC - 1);

	// bus decode
	logic                  req;
	logic                  wr_lane0;
	logic [ADR_W-1:0]      idx;
	logic                  ack_r;
	logic [31:0]           dat_r;
	logic [31:0]           rdata_nxt;

	// page select
	logic [PAGE_W-1:0]     page_r;
	logic                  pg_gain_a;
	logic                  pg_gain_b;
	logic                  pg_main_a;
	logic                  pg_main_b;

	// software-written registers, one copy per channel
	logic [GAIN_W-1:0]     gain_r     [NCH];
	logic                  rst_bit_r  [NCH];
	logic                  zen_r      [NCH];
	logic [ZSEL_W-1:0]     zsel_r     [NCH];

	// applied zone configuration
	logic                  zen_act_r  [NCH];
	logic [ZSEL_W-1:0]     zsel_act_r [NCH];
	logic [1:0]            pend;

	// core reset sequencer
	agz_seq_t              seq_r;
	agz_seq_t              seq_nxt;
	logic [2:0]            cnt_r;
	logic                  rst_any;
	logic                  rst_any_d_r;
	logic                  rst_rise;
	logic                  core_rst_r;

	logic                  wr_gain_sel [NCH];
	logic                  wr_main_sel [NCH];

	logic [SMP_W-1:0]      smp_in  [NCH];
	logic [SMP_W-1:0]      smp_out [NCH];
	logic [1:0]            band_tab_en;

	assign req       = wb_cyc_i & wb_stb_i & ~ack_r;
	assign idx       = wb_adr_i[11:2];
	assign wr_lane0  = req & wb_we_i & wb_sel_i[0];
	assign pg_gain_a = (page_r == PG_GAIN_A);
	assign pg_gain_b = (page_r == PG_GAIN_B);
	assign pg_main_a = (page_r == PG_MAIN_A);
	assign pg_main_b = (page_r == PG_MAIN_B);

	assign wr_gain_sel[0] = pg_gain_a;
	assign wr_gain_sel[1] = pg_gain_b;
	assign wr_main_sel[0] = pg_main_a;
	assign wr_main_sel[1] = pg_main_b;
	// the page select and status words answer on every page, so
	// software can always find its way back; only the per-channel
	// registers are gated by the page

	assign smp_in[0]   = smp_a_i;
	assign smp_in[1]   = smp_b_i;
	assign band_tab_en = {band_tab_en_b, band_tab_en_a};

	// one wait state: ack rises the edge after the request is seen
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			ack_r <= 1'b0;
		end else begin
			ack_r <= req;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			dat_r <= '0;
		end else if (req & ~wb_we_i) begin
			dat_r <= rdata_nxt;
		end
	end

	// page register spans three byte lanes
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			page_r <= PAGE_RST;
		end else if (req & wb_we_i & (idx == IDX_PAGE)) begin
			if (wb_sel_i[0]) begin
				page_r[7:0] <= wb_dat_i[7:0];
			end
			if (wb_sel_i[1]) begin
				page_r[15:8] <= wb_dat_i[15:8];
			end
			if (wb_sel_i[2]) begin
				page_r[23:16] <= wb_dat_i[23:16];
			end
		end
	end

	// per channel registers; reserved upper bits are never stored
	for (genvar c = 0; c < NCH; c++) begin : g_ch
		always_ff @(posedge mclk or posedge rst) begin
			if (rst) begin
				gain_r[c] <= GAIN_RST;
			end else if (wr_lane0 & wr_gain_sel[c] & (idx == IDX_GAIN)) begin
				gain_r[c] <= wb_dat_i[GAIN_LSB +: GAIN_W];
			end
		end

		always_ff @(posedge mclk or posedge rst) begin
			if (rst) begin
				rst_bit_r[c] <= CORE_RST_RST;
			end else if (wr_lane0 & wr_main_sel[c]
			             & (idx == IDX_CORE_RST)) begin
				rst_bit_r[c] <= wb_dat_i[RST_BIT];
			end
		end

		// enable and band are held here but not yet applied
		always_ff @(posedge mclk or posedge rst) begin
			if (rst) begin
				zen_r[c]  <= ZEN_RST;
				zsel_r[c] <= ZSEL_RST;
			end else if (wr_lane0 & wr_main_sel[c] & (idx == IDX_ZONE)) begin
				zen_r[c]  <= wb_dat_i[ZEN_BIT];
				zsel_r[c] <= wb_dat_i[ZSEL_LSB +: ZSEL_W];
			end
		end

		// new zone values reach the core only on a core reset pulse
		always_ff @(posedge mclk or posedge rst) begin
			if (rst) begin
				zen_act_r[c]  <= ZEN_RST;
				zsel_act_r[c] <= ZSEL_RST;
			end else if (rst_rise & (seq_r == AGZ_SEQ_IDLE)) begin
				zen_act_r[c]  <= zen_r[c];
				zsel_act_r[c] <= zsel_r[c];
			end
		end

		assign pend[c] = (zen_act_r[c] != zen_r[c])
		               | (zsel_act_r[c] != zsel_r[c]);

		agz_gain_scale #(
			.SW          (SMP_W)
		) u_gain (
			.mclk        (mclk),
			.rst         (rst),
			.core_rst    (core_rst_r),
			.gain_code   (gain_r[c]),
			.smp_in      (smp_in[c]),
			.smp_in_vld  (smp_vld_i),
			.smp_out     (smp_out[c]),
			.smp_out_vld (dwn_smp_vld[c])
		);
	end

	assign dwn_smp_a = smp_out[0];
	assign dwn_smp_b = smp_out[1];

	// either page's reset bit drives the one global reset
	assign rst_any  = rst_bit_r[0] | rst_bit_r[1];
	assign rst_rise = rst_any & ~rst_any_d_r;

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			rst_any_d_r <= 1'b0;
		end else begin
			rst_any_d_r <= rst_any;
		end
	end

	// fire on the rising half of the pulse, then wait for it to close
	always_comb begin
		seq_nxt = seq_r;
		unique case (seq_r)
			AGZ_SEQ_IDLE: begin
				if (rst_rise) begin
					seq_nxt = AGZ_SEQ_FIRE;
				end
			end
			AGZ_SEQ_FIRE: begin
				if (cnt_r == 3'h0) begin
					seq_nxt = AGZ_SEQ_HOLD;
				end
			end
			AGZ_SEQ_HOLD: begin
				if (!rst_any) begin
					seq_nxt = AGZ_SEQ_IDLE;
				end
			end
			default: begin
				seq_nxt = AGZ_SEQ_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			seq_r <= AGZ_SEQ_IDLE;
		end else begin
			seq_r <= seq_nxt;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			cnt_r <= 3'h0;
		end else if (seq_r == AGZ_SEQ_IDLE) begin
			cnt_r <= CNT_LOAD;
		end else if (cnt_r != 3'h0) begin
			cnt_r <= cnt_r - 3'h1;
		end
	end

	// core reset lasts a fixed time regardless of how long bit stays high
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			core_rst_r <= 1'b0;
		end else begin
			core_rst_r <= (seq_nxt == AGZ_SEQ_FIRE);
		end
	end

	// zone outputs from the applied copy only
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			zone_en_o     <= '0;
			zone_sel_a_o  <= ZSEL_RST;
			zone_sel_b_o  <= ZSEL_RST;
			zone_whole_o  <= '0;
		end else begin
			zone_en_o     <= {zen_act_r[1], zen_act_r[0]};
			zone_sel_a_o  <= zsel_act_r[0];
			zone_sel_b_o  <= zsel_act_r[1];
			// without table entries the band spans the whole spectrum
			zone_whole_o  <= {zen_act_r[1] & ~band_tab_en[1],
			                  zen_act_r[0] & ~band_tab_en[0]};
		end
	end

	// one-hot decode of the first three bands; zero when disabled
	function automatic logic [2:0] band_dec(input logic en,
	                                        input logic [2:0] code);
		logic [2:0] oh;
		oh = 3'h0;
		if (en) begin
			unique case (code)
				ZONE_FIRST:  oh = 3'h1;
				ZONE_SECOND: oh = 3'h2;
				ZONE_THIRD:  oh = 3'h4;
				default:     oh = 3'h0;
			endcase
		end
		return oh;
	endfunction : band_dec

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			zone_band_a_o <= 3'h0;
			zone_band_b_o <= 3'h0;
		end else begin
			zone_band_a_o <= band_dec(zen_act_r[0], zsel_act_r[0]);
			zone_band_b_o <= band_dec(zen_act_r[1], zsel_act_r[1]);
		end
	end

	// read mux; per-channel registers follow the current page, unmapped reads zero
	always_comb begin
		rdata_nxt = 32'h0000_0000;
		if (idx == IDX_PAGE) begin
			rdata_nxt[PAGE_W-1:0] = page_r;
		end else if (idx == IDX_STAT) begin
			rdata_nxt[ST_RST_BIT]              = core_rst_r;
			rdata_nxt[ST_PEND_LSB +: 2]        = pend;
			rdata_nxt[ST_ZONE_A_LSB +: ZSEL_W] = zsel_act_r[0];
			rdata_nxt[ST_ZONE_A_LSB + ZSEL_W]  = zen_act_r[0];
			rdata_nxt[ST_ZONE_B_LSB +: ZSEL_W] = zsel_act_r[1];
			rdata_nxt[ST_ZONE_B_LSB + ZSEL_W]  = zen_act_r[1];
		end else begin
			for (int c = 0; c < NCH; c++) begin
				if (wr_gain_sel[c] && idx == IDX_GAIN) begin
					rdata_nxt[GAIN_LSB +: GAIN_W] = gain_r[c];
				end
				if (wr_main_sel[c] && idx == IDX_CORE_RST) begin
					rdata_nxt[RST_BIT] = rst_bit_r[c];
				end
				if (wr_main_sel[c] && idx == IDX_ZONE) begin
					rdata_nxt[ZEN_BIT]            = zen_r[c];
					rdata_nxt[ZSEL_LSB +: ZSEL_W] = zsel_r[c];
				end
			end
		end
	end

	assign wb_ack_o   = ack_r;
	assign wb_dat_o   = dat_r;
	assign core_rst_o = core_rst_r;
endmodule : agz_cfg_regs

// ===== verification/agz_cfg_properties.sv
// port-level checks for the gain, zone and core reset register block
`timescale 1ns/10ps
module agz_cfg_properties
	import agz_pkg::*;
(
	input wire logic       mclk,
	input wire logic       rst,
	input wire logic       wb_cyc_i,
	input wire logic       wb_stb_i,
	input wire logic       wb_ack_o,
	input wire logic       smp_vld_i,
	input wire logic [1:0] dwn_smp_vld,
	input wire logic       band_tab_en_a,
	input wire logic       core_rst_o,
	input wire logic [1:0] zone_en_o,
	input wire logic [2:0] zone_sel_a_o,
	input wire logic [2:0] zone_sel_b_o,
	input wire logic [2:0] zone_band_a_o,
	input wire logic [2:0] zone_band_b_o,
	input wire logic [1:0] zone_whole_o
);
	logic whole_a;
	assign whole_a = zone_en_o[0] && !band_tab_en_a;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	sequence s_take;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence s_core_pulse;
		core_rst_o [*4] ##1 !core_rst_o;
	endsequence
	// registered flag may lag its inputs by one cycle
	sequence s_whole_steady;
		$stable(whole_a) ##1 $stable(whole_a);
	endsequence
	a_ack_follows: assert property (s_take |=> wb_ack_o)
		else $error("request not acknowledged in the next cycle");
	a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("acknowledge held longer than one cycle");
	a_ack_cause: assert property ($rose(wb_ack_o) |->
		$past(wb_cyc_i) && $past(wb_stb_i))
		else $error("acknowledge without a request");
	a_core_rst_len: assert property ($rose(core_rst_o) |-> s_core_pulse)
		else $error("core reset pulse length wrong");
	// applied zone reaches the outputs one cycle after the reset rises
	a_zone_on_pulse: assert property (
		$changed({zone_en_o, zone_sel_a_o, zone_sel_b_o}) |->
		core_rst_o && $past(core_rst_o) && !$past(core_rst_o, 2))
		else $error("applied zone changed without core reset");
	a_band_map_a: assert property (zone_band_a_o == (
		(zone_en_o[0] && zone_sel_a_o < 3'h3) ? 3'h1 << zone_sel_a_o : 3'h0))
		else $error("channel a band decode wrong");
	a_band_map_b: assert property (zone_band_b_o == (
		(zone_en_o[1] && zone_sel_b_o < 3'h3) ? 3'h1 << zone_sel_b_o : 3'h0))
		else $error("channel b band decode wrong");
	a_whole_flag: assert property (s_whole_steady |->
		zone_whole_o[0] == whole_a)
		else $error("whole spectrum flag wrong");
	a_vld_follow: assert property (!$past(rst) && $past(smp_vld_i)
		&& !core_rst_o && !$past(core_rst_o) |-> dwn_smp_vld == 2'h3)
		else $error("sample valid does not follow input");
endmodule : agz_cfg_properties

bind agz_cfg_regs agz_cfg_properties u_agz_cfg_properties (.mclk, .rst,
	.wb_cyc_i, .wb_stb_i, .wb_ack_o, .smp_vld_i, .dwn_smp_vld,
	.band_tab_en_a, .core_rst_o, .zone_en_o, .zone_sel_a_o, .zone_sel_b_o,
	.zone_band_a_o, .zone_band_b_o, .zone_whole_o);

// ===== verification/test_adc_gain_zone_reset_cfg.sv
// self-checking bench for the gain, zone and core reset registers
`timescale 1ns/10ps
module test_adc_gain_zone_reset_cfg;
	import agz_pkg::*;
	logic        mclk, rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic        smp_vld_i, band_tab_en_a, band_tab_en_b, core_rst_o;
	logic [11:0] wb_adr_i;
	logic [3:0]  wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o, rd;
	logic [13:0] smp_a_i, smp_b_i, dwn_smp_a, dwn_smp_b;
	logic [1:0]  dwn_smp_vld, zone_en_o, zone_whole_o;
	logic [2:0]  zone_sel_a_o, zone_sel_b_o, zone_band_a_o, zone_band_b_o;
	int          mismatches, comparisons, cycles, rst_hi;

	agz_cfg_regs u_agz_cfg_regs (.mclk, .rst, .wb_cyc_i, .wb_stb_i,
		.wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
		.smp_a_i, .smp_b_i, .smp_vld_i, .dwn_smp_a, .dwn_smp_b,
		.dwn_smp_vld, .band_tab_en_a, .band_tab_en_b, .core_rst_o,
		.zone_en_o, .zone_sel_a_o, .zone_sel_b_o, .zone_band_a_o,
		.zone_band_b_o, .zone_whole_o);

	initial mclk = 1'b0;
	always #12.5 mclk = ~mclk;

	// core_rst_o is only counted while it is high, so clearing is race free
	always @(posedge mclk) begin
		cycles++;
		if (core_rst_o === 1'b1)
			rst_hi++;
		if (cycles == 5000) begin
			mismatches++;
			report_and_stop();
		end
	end

	task automatic report_and_stop();
		$display("mismatches %0d comparisons %0d", mismatches, comparisons);
		if (mismatches == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : report_and_stop

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic acc(input logic we, input logic [9:0] idx,
		input logic [31:0] d);
		@(posedge mclk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= we;
		wb_adr_i <= {idx, 2'b00};
		wb_sel_i <= 4'hF;
		wb_dat_i <= d;
		do @(posedge mclk); while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask : acc

	task automatic rd_chk(input logic [9:0] idx, input logic [31:0] exp);
		acc(1'b0, idx, 32'h0);
		chk(rd, exp);
	endtask : rd_chk

	// floor of the fixed-point product, clipped to 14-bit signed
	function automatic logic [13:0] gexp(input int s, input int k);
		int p;
		p = (s * int'(GAIN_LUT[k])) >>> 12;
		if (p > 8191)
			p = 8191;
		if (p < -8192)
			p = -8192;
		return p[13:0];
	endfunction : gexp

	task automatic pulse(input logic [23:0] pg);
		acc(1'b1, IDX_PAGE, {8'h00, pg});
		rst_hi = 0;
		acc(1'b1, IDX_CORE_RST, 32'h1);
		// status is read and the samples looked at while the reset stands
		acc(1'b0, IDX_STAT, 32'h0);
		chk(rd[ST_RST_BIT], 1'b1);
		chk({dwn_smp_vld, dwn_smp_a, dwn_smp_b}, 30'h0);
		repeat (5) @(posedge mclk);
		acc(1'b1, IDX_CORE_RST, 32'h0);
		chk(rst_hi, CORE_RST_CYC);
	endtask : pulse

	task automatic t_regs();
		rd_chk(IDX_GAIN, 32'h0);
		acc(1'b1, IDX_PAGE, {8'h00, PG_GAIN_A});
		rd_chk(IDX_GAIN, 32'h0);
		rd_chk(IDX_ZONE, 32'h0);
		acc(1'b1, IDX_PAGE, {8'h00, PG_MAIN_B});
		rd_chk(IDX_CORE_RST, 32'h0);
		rd_chk(IDX_ZONE, 32'h0);
		rd_chk(10'h3FF, 32'h0);
		acc(1'b1, IDX_ZONE, 32'hF0);
		rd_chk(IDX_ZONE, 32'h0);
		$display("register reset test done");
	endtask : t_regs

	task automatic t_gain();
		acc(1'b1, IDX_PAGE, {8'h00, PG_GAIN_A});
		for (int k = 0; k < 13; k++) begin
			acc(1'b1, IDX_GAIN, k);
			repeat (3) @(posedge mclk);
			chk(dwn_smp_a, gexp(1000, k < 12 ? k : 0));
			chk(dwn_smp_b, 14'h3C18);
		end
		smp_a_i <= 14'h1B58;
		acc(1'b1, IDX_GAIN, 32'hFB);
		rd_chk(IDX_GAIN, 32'hB);
		repeat (3) @(posedge mclk);
		chk(dwn_smp_a, 14'h1FFF);
		acc(1'b1, IDX_PAGE, {8'h00, PG_GAIN_B});
		rd_chk(IDX_GAIN, 32'h0);
		acc(1'b1, IDX_GAIN, 32'h6);
		repeat (3) @(posedge mclk);
		chk(dwn_smp_b, gexp(-1000, 6));
		chk(dwn_smp_a, 14'h1FFF);
		$display("gain test done");
	endtask : t_gain

	task automatic t_zone();
		logic [3:0] prev;
		prev = 4'h0;
		for (int z = 0; z < 4; z++) begin
			acc(1'b1, IDX_PAGE, {8'h00, PG_MAIN_A});
			acc(1'b1, IDX_ZONE, 32'h8);
			acc(1'b1, IDX_ZONE, 32'h8 | z);
			chk({zone_en_o[0], zone_sel_a_o}, prev);
			rd_chk(IDX_STAT, {24'h0, prev, 4'h2});
			pulse(z[0] ? PG_MAIN_B : PG_MAIN_A);
			prev = {1'b1, z[2:0]};
			chk({zone_en_o[0], zone_sel_a_o}, prev);
			chk(zone_band_a_o, z < 3 ? 3'b001 << z : 3'b000);
			chk(zone_whole_o[0], 1'b1);
		end
		band_tab_en_a <= 1'b1;
		repeat (3) @(posedge mclk);
		chk(zone_whole_o[0], 1'b0);
		band_tab_en_a <= 1'b0;
		acc(1'b1, IDX_PAGE, {8'h00, PG_MAIN_B});
		acc(1'b1, IDX_ZONE, 32'h8);
		acc(1'b1, IDX_ZONE, 32'hA);
		acc(1'b1, IDX_PAGE, {8'h00, PG_MAIN_A});
		acc(1'b1, IDX_ZONE, 32'h0);
		pulse(PG_MAIN_A);
		chk(zone_sel_b_o, 3'h2);
		chk(zone_band_b_o, 3'b100);
		chk(zone_en_o, 2'b10);
		chk(zone_band_a_o, 3'b000);
		chk(zone_whole_o, 2'b10);
		rd_chk(IDX_STAT, 32'hA00);
		$display("zone and core reset test done");
	endtask : t_zone

	initial begin
		rst = 1'b1;
		wb_cyc_i = 1'b0;
		wb_stb_i = 1'b0;
		wb_we_i = 1'b0;
		wb_adr_i = 12'h000;
		wb_sel_i = 4'h0;
		wb_dat_i = 32'h0;
		smp_a_i = 14'h03E8;
		smp_b_i = 14'h3C18;
		smp_vld_i = 1'b0;
		band_tab_en_a = 1'b0;
		band_tab_en_b = 1'b0;
		mismatches = 0;
		comparisons = 0;
		cycles = 0;
		rst_hi = 0;
		repeat (3) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		smp_vld_i <= 1'b1;
		t_regs();
		t_gain();
		t_zone();
		report_and_stop();
	end
endmodule : test_adc_gain_zone_reset_cfg
